// [include/cdns_params.svh]
// register indices, field positions and reset values of the calibration
// dds, oscillator sync and serial-control enable register slice.
// assumes byte address on apb = 4 * register index.
`ifndef CDNS_PARAMS_SVH
`define CDNS_PARAMS_SVH

// register indices
`define CDNS_IDX_SER_EN 10'h1DE
`define CDNS_IDX_FTW_B0 10'h1E2
`define CDNS_IDX_FTW_B1 10'h1E3
`define CDNS_IDX_FTW_B2 10'h1E4
`define CDNS_IDX_FTW_B3 10'h1E5
`define CDNS_IDX_MODE 10'h1E6
`define CDNS_IDX_SYNC 10'h1E7
`define CDNS_IDX_IRQ_STAT 10'h1F0
`define CDNS_IDX_IRQ_MASK 10'h1F1
`define CDNS_IDX_TRIG_SEL 10'h1F2

// field positions
`define CDNS_SER_EN_HI 1
`define CDNS_SER_EN_LO 0
`define CDNS_MODE_ACC 2
`define CDNS_MODE_DC 1
`define CDNS_MODE_TUNE 0
`define CDNS_SYNC_ACK 1
`define CDNS_SYNC_START 0
`define CDNS_TRIG_SYSREF 0

// reset values
`define CDNS_RST_SER_EN 2'h3
`define CDNS_RST_FTW 32'h0000_0000
`define CDNS_RST_MODE 3'h0
`define CDNS_RST_SYNC 1'h0

`endif

// [include/cdns_pkg.sv]
// types shared by the calibration dds / oscillator sync register slice.
// assumes two converter channels, each with its own paged copy.
package cdns_pkg;

    // number of converter channels with a paged copy
    localparam int NDAC = 2;

    // calibration mode bits of one converter
    typedef struct packed {
        logic acc_en;   // accumulator clock enable
        logic dc_sel;   // final dds input select
        logic tune_en;  // calibration frequency tuning
    } cdns_mode_s;

    // control bundle handed to one converter's datapath
    typedef struct packed {
        logic [31:0] cal_tuning_word;          // applied tuning word
        logic cal_accumulator_enable;          // gates the accumulator clock
        logic final_dds_dc_input_select;       // 1: dc into the final dds
        logic cal_frequency_tune_enable;       // converter 0 only
    } cdns_dac_ctrl_s;

    // oscillator sync sequencer, one-hot
    typedef enum logic [2:0] {
        SY_IDLE = 3'b001,
        SY_LOAD = 3'b010,
        SY_SYNC = 3'b100
    } cdns_sync_e;

endpackage : cdns_pkg

// [core/cdns_regs.sv]
// apb register slice: calibration tuning word and mode, oscillator sync
// start / acknowledge, serial-control enables, sync-done interrupt.
// assumes the page select is driven from a register elsewhere on pclk,
// and the oscillator datapaths answer the load request on pclk.
//
// Summary of operation
// (R1) 32-bit tuning word in four bytes, reset zero
// (R2) tuning, mode and sync stored per converter, paged
// (R3) software enables accumulator before writing tuning word
// (R4) accumulator clock follows its enable bit
// (R5) dc-input bit picks datapath or dc
// (R6) tuning enable acts on converter zero only
// (R7) sync starts on start-bit or sysref rising edge
// (R8) load tuning words first, then phase sync
// (R9) acknowledge bit set once oscillators loaded
// (R10) acknowledge also marks reset-after-rotation completion
// (R11) reserved bits read zero, ignore writes
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "cdns_params.svh"

module cdns_regs
    import cdns_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NDAC-1:0] main_converter_page_select,
    input wire logic sysref_pin,
    input wire logic oscillator_reset_after_rotation_enable,
    input wire logic [NDAC-1:0] rotation_reset_done,
    input wire logic [NDAC-1:0] nco_load_done,
    output logic [NDAC-1:0] nco_ftw_load_req,
    output logic [NDAC-1:0] nco_phase_sync,
    output cdns_dac_ctrl_s [NDAC-1:0] dac_ctrl,
    output logic serial_ctrl_enable_hi,
    output logic serial_ctrl_enable_lo,
    output logic irq
);

    // register index of a byte address
    function automatic logic [9:0] reg_idx(input logic [11:0] a);
        reg_idx = a[11:2];
    endfunction : reg_idx

    // true when the index is one of the four tuning word bytes
    function automatic logic is_ftw(input logic [9:0] i);
        is_ftw = (i >= `CDNS_IDX_FTW_B0) && (i <= `CDNS_IDX_FTW_B3);
    endfunction : is_ftw

    // converter copy shown on reads: lowest selected page wins
    function automatic int unsigned rd_dac(input logic [NDAC-1:0] pg);
        rd_dac = (pg[0] || !pg[1]) ? 0 : 1;
    endfunction : rd_dac

    logic [9:0] idx;                       // decoded register index
    logic mapped;                          // index hits a register
    logic wr_en;                           // write takes effect now
    logic rd_acc;                          // read access completes now
    logic [1:0] ser_en_q;                  // serial-control enables
    logic [31:0] ftw_q [NDAC];             // software tuning word copies
    logic [31:0] ftw_applied_q [NDAC];     // word the accumulator uses
    cdns_mode_s mode_q [NDAC];             // per-converter mode bits
    logic start_q [NDAC];                  // sync start bit
    logic start_prev_q [NDAC];             // start bit one cycle ago
    logic ack_q [NDAC];                    // loaded acknowledge
    cdns_sync_e st_q [NDAC];               // sync sequencer state
    logic trig_sysref_q;                   // 1: sysref is the trigger
    logic [NDAC-1:0] irq_stat_q;           // sticky sync-done events
    logic [NDAC-1:0] irq_mask_q;           // 1: event reaches irq
    logic [NDAC-1:0] ack_set;              // acknowledge set events
    logic [NDAC-1:0] trig;                 // sync trigger per converter
    logic sy1_q, sy2_q, sy3_q;             // sysref synchroniser
    logic sysref_lvl_q;                    // debounced sysref level
    logic sysref_rise;                     // accepted sysref rising edge
    logic [31:0] rdata_d;                  // read mux
    logic [31:0] prdata_q;                 // read data sampled in setup

    assign idx = reg_idx(paddr);
    assign mapped = (idx == `CDNS_IDX_SER_EN) || is_ftw(idx) ||
                    (idx == `CDNS_IDX_MODE) || (idx == `CDNS_IDX_SYNC) ||
                    (idx == `CDNS_IDX_IRQ_STAT) ||
                    (idx == `CDNS_IDX_IRQ_MASK) ||
                    (idx == `CDNS_IDX_TRIG_SEL);
    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_acc = psel && penable && !pwrite;
    assign prdata = prdata_q;

    // read mux; shows the paged copy of the selected converter
    always_comb begin
        int unsigned d;
        d = rd_dac(main_converter_page_select);
        rdata_d = 32'h0000_0000;
        // (R11) reserved bits zero
        unique case (1'b1)
            (idx == `CDNS_IDX_SER_EN): rdata_d[1:0] = ser_en_q;
            (idx == `CDNS_IDX_FTW_B0): rdata_d[7:0] = ftw_q[d][7:0];
            (idx == `CDNS_IDX_FTW_B1): rdata_d[7:0] = ftw_q[d][15:8];
            (idx == `CDNS_IDX_FTW_B2): rdata_d[7:0] = ftw_q[d][23:16];
            (idx == `CDNS_IDX_FTW_B3): rdata_d[7:0] = ftw_q[d][31:24];
            (idx == `CDNS_IDX_MODE): rdata_d[2:0] = mode_q[d];
            (idx == `CDNS_IDX_SYNC): begin
                rdata_d[`CDNS_SYNC_ACK] = ack_q[d];
                rdata_d[`CDNS_SYNC_START] = start_q[d];
            end
            (idx == `CDNS_IDX_IRQ_STAT): rdata_d[NDAC-1:0] = irq_stat_q;
            (idx == `CDNS_IDX_IRQ_MASK): rdata_d[NDAC-1:0] = irq_mask_q;
            (idx == `CDNS_IDX_TRIG_SEL): rdata_d[0] = trig_sysref_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // capture read data in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    // serial-control enables, shared by both converters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_en_q <= `CDNS_RST_SER_EN;
        end else if (wr_en && idx == `CDNS_IDX_SER_EN) begin
            ser_en_q <= pwdata[1:0];
        end
    end
    assign serial_ctrl_enable_hi = ser_en_q[`CDNS_SER_EN_HI];
    assign serial_ctrl_enable_lo = ser_en_q[`CDNS_SER_EN_LO];

    // trigger select and interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sysref_q <= 1'b0;
            irq_mask_q <= '0;
        end else if (wr_en) begin
            if (idx == `CDNS_IDX_TRIG_SEL) begin
                trig_sysref_q <= pwdata[`CDNS_TRIG_SYSREF];
            end
            if (idx == `CDNS_IDX_IRQ_MASK) begin
                irq_mask_q <= pwdata[NDAC-1:0];
            end
        end
    end

    // paged tuning word and mode bits; writes reach every selected page
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDAC; i++) begin
                ftw_q[i] <= `CDNS_RST_FTW;
                mode_q[i] <= `CDNS_RST_MODE;
            end
        end else if (wr_en) begin
            for (int i = 0; i < NDAC; i++) begin
                // (R2) paged per converter
                if (main_converter_page_select[i]) begin
                    // (R1) byte lanes of word
                    unique case (1'b1)
                        (idx == `CDNS_IDX_FTW_B0): ftw_q[i][7:0] <= pwdata[7:0];
                        (idx == `CDNS_IDX_FTW_B1): ftw_q[i][15:8] <= pwdata[7:0];
                        (idx == `CDNS_IDX_FTW_B2):
                            ftw_q[i][23:16] <= pwdata[7:0];
                        (idx == `CDNS_IDX_FTW_B3):
                            ftw_q[i][31:24] <= pwdata[7:0];
                        // (R11) only defined bits stored
                        (idx == `CDNS_IDX_MODE): mode_q[i] <= pwdata[2:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // the accumulator only picks up a word on a byte write while it is clocked;
    // a byte written while disabled stays in the readback copy until the next such write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDAC; i++) begin
                ftw_applied_q[i] <= `CDNS_RST_FTW;
            end
        end else begin
            for (int i = 0; i < NDAC; i++) begin
                // (R3) enable precedes word
                if (wr_en && is_ftw(idx) && main_converter_page_select[i] &&
                    mode_q[i].acc_en) begin
                    ftw_applied_q[i] <= ftw_q[i];
                    unique case (idx)
                        `CDNS_IDX_FTW_B0: ftw_applied_q[i][7:0] <= pwdata[7:0];
                        `CDNS_IDX_FTW_B1:
                            ftw_applied_q[i][15:8] <= pwdata[7:0];
                        `CDNS_IDX_FTW_B2:
                            ftw_applied_q[i][23:16] <= pwdata[7:0];
                        default: ftw_applied_q[i][31:24] <= pwdata[7:0];
                    endcase
                end
            end
        end
    end

    // datapath control bundles
    always_comb begin
        for (int i = 0; i < NDAC; i++) begin
            dac_ctrl[i].cal_tuning_word = ftw_applied_q[i];
            // (R4) clock gate enable
            dac_ctrl[i].cal_accumulator_enable = mode_q[i].acc_en;
            // (R5) dc or datapath
            dac_ctrl[i].final_dds_dc_input_select = mode_q[i].dc_sel;
            // (R6) converter zero only
            dac_ctrl[i].cal_frequency_tune_enable =
                (i == 0) ? mode_q[i].tune_en : 1'b0;
        end
    end

    // sysref: three flops, a change counts once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1_q <= 1'b0;
            sy2_q <= 1'b0;
            sy3_q <= 1'b0;
            sysref_lvl_q <= 1'b0;
        end else begin
            sy1_q <= sysref_pin;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            if (sy2_q == sy3_q) begin
                sysref_lvl_q <= sy3_q;
            end
        end
    end
    assign sysref_rise = sy2_q && sy3_q && !sysref_lvl_q;

    // sync start bit per page; its rising edge is a trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDAC; i++) begin
                start_q[i] <= `CDNS_RST_SYNC;
                start_prev_q[i] <= `CDNS_RST_SYNC;
            end
        end else begin
            for (int i = 0; i < NDAC; i++) begin
                start_prev_q[i] <= start_q[i];
                if (wr_en && idx == `CDNS_IDX_SYNC &&
                    main_converter_page_select[i]) begin
                    start_q[i] <= pwdata[`CDNS_SYNC_START];
                end
            end
        end
    end

    // (R7) trigger per configured source
    always_comb begin
        for (int i = 0; i < NDAC; i++) begin
            trig[i] = trig_sysref_q ? sysref_rise
                                    : (start_q[i] && !start_prev_q[i]);
        end
    end

    // sequencer: request the tuning word load, then pulse phase sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDAC; i++) begin
                st_q[i] <= SY_IDLE;
            end
        end else begin
            for (int i = 0; i < NDAC; i++) begin
                unique case (st_q[i])
                    SY_IDLE: if (trig[i]) st_q[i] <= SY_LOAD;
                    // (R8) load before sync
                    SY_LOAD: if (nco_load_done[i]) st_q[i] <= SY_SYNC;
                    SY_SYNC: st_q[i] <= SY_IDLE;
                    default: st_q[i] <= SY_IDLE;
                endcase
            end
        end
    end

    // handshake outputs decoded from the state
    always_comb begin
        for (int i = 0; i < NDAC; i++) begin
            nco_ftw_load_req[i] = (st_q[i] == SY_LOAD);
            nco_phase_sync[i] = (st_q[i] == SY_SYNC);
        end
    end

    // acknowledge set events from either reset method
    always_comb begin
        for (int i = 0; i < NDAC; i++) begin
            // (R9) loaded acknowledge
            // (R10) rotation reset too
            ack_set[i] = (st_q[i] == SY_LOAD && nco_load_done[i]) ||
                (oscillator_reset_after_rotation_enable &&
                 rotation_reset_done[i]);
        end
    end

    // acknowledge clears when a new request is accepted; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NDAC; i++) begin
                ack_q[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NDAC; i++) begin
                if (ack_set[i]) begin
                    ack_q[i] <= 1'b1;
                end else if (st_q[i] == SY_IDLE && trig[i]) begin
                    ack_q[i] <= 1'b0;
                end
            end
        end
    end

    // sticky status, cleared by reading it; only bits that were captured
    // for the reader are cleared, so a late event is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            if (rd_acc && idx == `CDNS_IDX_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~prdata_q[NDAC-1:0]) | ack_set;
            end else begin
                irq_stat_q <= irq_stat_q | ack_set;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_FTW_ZERO_AFTER_RESET: assert property ( // (R1)
        $rose(presetn) |-> ftw_q[0] == 32'h0000_0000)
        else $error("tuning word not zero after reset");
    AST_PAGE_ISOLATION: assert property ( // (R2)
        wr_en && !main_converter_page_select[1] |=> $stable(ftw_q[1]))
        else $error("unselected page written");
    AST_APPLY_NEEDS_ENABLE: assert property ( // (R3)
        !mode_q[0].acc_en |=> $stable(ftw_applied_q[0]))
        else $error("word applied while accumulator disabled");
    AST_CLK_GATE: assert property ( // (R4)
        wr_en && idx == `CDNS_IDX_MODE && main_converter_page_select[1]
        |=> dac_ctrl[1].cal_accumulator_enable == $past(pwdata[2]))
        else $error("accumulator clock enable not following write");
    AST_DC_SEL: assert property ( // (R5)
        wr_en && idx == `CDNS_IDX_MODE && main_converter_page_select[0]
        |=> dac_ctrl[0].final_dds_dc_input_select == $past(pwdata[1]))
        else $error("dc select not following write");
    AST_TUNE_DAC1_OFF: assert property ( // (R6)
        wr_en && idx == `CDNS_IDX_MODE && main_converter_page_select[0]
        |=> dac_ctrl[0].cal_frequency_tune_enable == $past(pwdata[0]) &&
            !dac_ctrl[1].cal_frequency_tune_enable)
        else $error("tuning enable not limited to converter zero");
    AST_TRIGGER_STARTS: assert property ( // (R7)
        st_q[0] == SY_IDLE && trig[0] |=> nco_ftw_load_req[0])
        else $error("trigger did not start load");
    AST_LOAD_THEN_SYNC: assert property ( // (R8)
        nco_phase_sync[0] |-> $past(nco_ftw_load_req[0]) &&
        $past(nco_load_done[0]) ##1 !nco_phase_sync[0])
        else $error("phase sync without prior load");
    AST_ACK_ON_LOAD: assert property ( // (R9)
        nco_ftw_load_req[0] && nco_load_done[0] |=> ack_q[0] && irq_stat_q[0])
        else $error("acknowledge missing after load");
    AST_ACK_ROTATION: assert property ( // (R10)
        oscillator_reset_after_rotation_enable && rotation_reset_done[1]
        |=> ack_q[1])
        else $error("acknowledge missing after rotation reset");
    AST_RESERVED_ZERO: assert property ( // (R11)
        psel && !penable && !pwrite && idx == `CDNS_IDX_MODE
        |=> prdata[31:3] == 29'h0)
        else $error("reserved bits read nonzero");

    COV_SYNC_DONE: cover property (
        nco_ftw_load_req[0] ##[1:20] nco_phase_sync[0]);
    COV_SYSREF_TRIG: cover property (trig_sysref_q && sysref_rise);
    COV_IRQ: cover property ($rose(irq));
    COV_SLVERR: cover property (pslverr);

endmodule : cdns_regs

// [verification/cal_dds_nco_sync_regs_tb_top.sv]
// self-checking bench for the calibration dds / oscillator sync slice.
// assumes cdns_regs with two converters, apb at 4 * index, pready high.
`timescale 1ns/1ps
`include "cdns_params.svh"

module cal_dds_nco_sync_regs_tb_top
    import cdns_pkg::*;
();
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NDAC-1:0] page;  // converter page select
    logic sysref_pin;
    logic rot_en;  // reset-after-rotation enable
    logic [NDAC-1:0] rot_done;
    logic [NDAC-1:0] nco_load_done;
    logic [NDAC-1:0] nco_ftw_load_req;
    logic [NDAC-1:0] nco_phase_sync;
    cdns_dac_ctrl_s [NDAC-1:0] dac_ctrl;
    logic ser_hi;
    logic ser_lo;
    logic irq;
    logic [31:0] rd;  // last read data
    logic err;  // last slave error
    logic seen;  // request seen flag
    int n_mismatch;
    int cmp_count;
    int cyc;  // timeout counter

    cdns_regs dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .main_converter_page_select(page),
        .sysref_pin(sysref_pin),
        .oscillator_reset_after_rotation_enable(rot_en),
        .rotation_reset_done(rot_done),
        .nco_load_done(nco_load_done),
        .nco_ftw_load_req(nco_ftw_load_req),
        .nco_phase_sync(nco_phase_sync),
        .dac_ctrl(dac_ctrl),
        .serial_ctrl_enable_hi(ser_hi),
        .serial_ctrl_enable_lo(ser_lo),
        .irq(irq)
    );

    // 200 mhz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // verdict and end of run, the only exit
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // case-equality compare, four-state safe
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; waits on pready, bounded by the timeout only
    task automatic apb(input logic [9:0] idx, input logic wr,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0000_0000);
        chk(rd, exp, "read data");
    endtask : rchk

    // wait a settled moment after the next edge
    task automatic tick();
        @(posedge pclk);
        #1;
    endtask : tick

    // answer one load request of converter c, then expect the sync pulse
    task automatic load_walk(input int c);
        int n;
        n = 0;
        while (nco_ftw_load_req[c] !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        chk(nco_ftw_load_req[c], 1'b1, "load request");
        chk(nco_phase_sync[c], 1'b0, "sync before load");
        @(posedge pclk);
        nco_load_done[c] <= 1'b1;
        @(posedge pclk);
        nco_load_done[c] <= 1'b0;
        #1;
        chk(nco_phase_sync[c], 1'b1, "sync pulse");
        chk(nco_ftw_load_req[c], 1'b0, "request dropped");
        tick();
        chk(nco_phase_sync[c], 1'b0, "pulse width");
    endtask : load_walk

    // hang guard: the whole run is under two hundred cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sysref_pin, rot_en, rot_done, nco_load_done} = '0;
        page = 2'h1;
        presetn = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, reserved bits, unmapped index
        rchk(`CDNS_IDX_SER_EN, 32'h0000_0003);
        for (int k = 0; k < 4; k++) begin
            rchk(`CDNS_IDX_FTW_B0 + 10'(k), 32'h0000_0000);
        end
        rchk(`CDNS_IDX_MODE, 32'h0000_0000);
        rchk(`CDNS_IDX_SYNC, 32'h0000_0000);
        apb(`CDNS_IDX_SER_EN, 1'b1, 32'hFFFF_FFFE);
        rchk(`CDNS_IDX_SER_EN, 32'h0000_0002);
        chk({ser_hi, ser_lo}, 32'h0000_0002, "serial enables");
        apb(10'h1E0, 1'b1, 32'hFFFF_FFFF);
        chk(err, 1'b1, "unmapped write");
        apb(10'h1E0, 1'b0, 32'h0000_0000);
        chk(err, 1'b1, "unmapped read");
        chk(rd, 32'h0000_0000, "unmapped data");
        $display("test reset done");
        // tuning word while disabled, then enabled; mode bits
        for (int k = 0; k < 4; k++) begin
            apb(`CDNS_IDX_FTW_B0 + 10'(k), 1'b1, 32'(8'h11 * (k + 1)));
        end
        tick();
        chk(dac_ctrl[0].cal_tuning_word, 32'h0, "word disabled");
        rchk(`CDNS_IDX_FTW_B3, 32'h0000_0044);
        // enable goes in before the word, as software must
        apb(`CDNS_IDX_MODE, 1'b1, 32'h0000_0004);
        tick();
        chk(dac_ctrl[0].cal_accumulator_enable, 1'b1, "acc clock");
        apb(`CDNS_IDX_FTW_B3, 1'b1, 32'h0000_0044);
        tick();
        chk(dac_ctrl[0].cal_tuning_word, 32'h4433_2211, "word");
        apb(`CDNS_IDX_MODE, 1'b1, 32'hFFFF_FFFF);
        rchk(`CDNS_IDX_MODE, 32'h0000_0007);
        chk(dac_ctrl[0].final_dds_dc_input_select, 1'b1, "dc sel");
        chk(dac_ctrl[0].cal_frequency_tune_enable, 1'b1, "tune 0");
        apb(`CDNS_IDX_MODE, 1'b1, 32'h0000_0001);
        tick();
        chk(dac_ctrl[0].final_dds_dc_input_select, 1'b0, "dc off");
        chk(dac_ctrl[0].cal_accumulator_enable, 1'b0, "acc off");
        // second converter page
        page <= 2'h2;
        apb(`CDNS_IDX_FTW_B0, 1'b1, 32'h0000_00A5);
        apb(`CDNS_IDX_MODE, 1'b1, 32'h0000_0003);
        rchk(`CDNS_IDX_FTW_B0, 32'h0000_00A5);
        rchk(`CDNS_IDX_MODE, 32'h0000_0003);
        chk(dac_ctrl[1].cal_frequency_tune_enable, 1'b0, "tune 1");
        chk(dac_ctrl[1].final_dds_dc_input_select, 1'b1, "dc 1");
        chk(dac_ctrl[0].final_dds_dc_input_select, 1'b0, "dc 0");
        page <= 2'h1;
        rchk(`CDNS_IDX_FTW_B0, 32'h0000_0011);
        $display("test tuning done");
        // start-bit sync, acknowledge, masked then unmasked interrupt
        apb(`CDNS_IDX_SYNC, 1'b1, 32'h0000_0001);
        load_walk(0);
        rchk(`CDNS_IDX_SYNC, 32'h0000_0003);
        chk(irq, 1'b0, "irq masked");
        apb(`CDNS_IDX_IRQ_MASK, 1'b1, 32'h0000_0003);
        tick();
        chk(irq, 1'b1, "irq raised");
        rchk(`CDNS_IDX_IRQ_STAT, 32'h0000_0001);
        tick();
        chk(irq, 1'b0, "irq cleared");
        rchk(`CDNS_IDX_IRQ_STAT, 32'h0000_0000);
        // start bit already high: no rising edge, no sequence
        apb(`CDNS_IDX_SYNC, 1'b1, 32'h0000_0001);
        seen = 1'b0;
        repeat (8) begin
            tick();
            seen = seen | nco_ftw_load_req[0];
        end
        chk(seen, 1'b0, "level no trigger");
        $display("test start bit done");
        // sysref as trigger
        apb(`CDNS_IDX_SYNC, 1'b1, 32'h0000_0000);
        apb(`CDNS_IDX_TRIG_SEL, 1'b1, 32'h0000_0001);
        @(posedge pclk);
        sysref_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        sysref_pin <= 1'b0;
        load_walk(0);
        rchk(`CDNS_IDX_SYNC, 32'h0000_0002);
        $display("test sysref done");
        // reset-after-rotation completion on converter 1
        page <= 2'h2;
        rchk(`CDNS_IDX_SYNC, 32'h0000_0000);
        // completion while the method is disabled must not acknowledge
        @(posedge pclk);
        rot_done <= 2'h2;
        @(posedge pclk);
        rot_done <= 2'h0;
        rchk(`CDNS_IDX_SYNC, 32'h0000_0000);
        @(posedge pclk);
        rot_en <= 1'b1;
        rot_done <= 2'h2;
        @(posedge pclk);
        rot_done <= 2'h0;
        rchk(`CDNS_IDX_SYNC, 32'h0000_0002);
        $display("test rotation done");
        test_done();
    end
endmodule : cal_dds_nco_sync_regs_tb_top
